// >>> hdl/meas_cmd_cfg.svh
// Constants of the measurement command and readout logic.
// Assumes a serial front end that delivers command bytes and read requests.
`ifndef MEAS_CMD_CFG_SVH
`define MEAS_CMD_CFG_SVH
`define CMD_START_CYCLIC 8'hab
`define CMD_STOP_CYCLIC  8'hbf
`define CMD_RAW_BOTH     8'ha0
`define CMD_RAW_SENSOR   8'ha1
`define CMD_RAW_TEMP     8'ha2
`define CMD_CORR_BASE    8'hb0
`define CMD_CORR_MASK    8'hf8
`define STAT_BUSY_BIT    5
`define STAT_CYCLIC_BIT  3
`define STAT_CMD_BIT     4
`define STAT_SLEEP_BIT   2
`define STAT_SAT_BIT     0
`define STAT_POWER_BIT   6
`define RESULT_BYTES     3
`define COEF_GAIN_RESET  24'h010000
`endif

// >>> hdl/meas_cmd_pkg.sv
// Types shared by the measurement command logic.
// Assumes nothing beyond the cfg header.
package meas_cmd_pkg;
  typedef enum logic [1:0]
  {
    TGT_BOTH   = 2'h0,
    TGT_SENSOR = 2'h1,
    TGT_TEMP   = 2'h2
  } target_t;
  typedef struct packed
  {
    logic [7:0] data;
  } byte_t;
  typedef struct packed
  {
    logic [23:0] sensor;
    logic [23:0] temp;
  } sample_t;
endpackage

// >>> hdl/meas_cmd_readout.sv
// Measurement command interpreter and readout sequencer.
// Assumes a front end that gives decoded command bytes and read requests
// and a converter that returns raw samples on request.
`include "meas_cmd_cfg.svh"
module meas_cmd_readout
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Command bytes from the link
  input  wire logic                  cmd_valid_i,
  input  wire logic [7:0]            cmd_data_i,
  output      logic                  cmd_reject_o,
  // Read request and byte stream to the link
  input  wire logic                  read_req_i,
  output      logic                  rd_valid_o,
  input  wire logic                  rd_ready_i,
  output      meas_cmd_pkg::byte_t   rd_data_o,
  // Converter
  output      logic                  conv_start_o,
  input  wire logic                  conv_done_i,
  input  wire meas_cmd_pkg::sample_t conv_data_i,
  input  wire logic                  sleep_i,
  // Calibration coefficients
  input  wire logic [23:0]           coef_gain_i,
  input  wire logic [23:0]           coef_offset_i,
  // Mode view
  output      logic                  busy_o,
  output      logic                  cyclic_o
);
  import meas_cmd_pkg::*;

  typedef enum logic [3:0]
  {
    M_IDLE = 4'h1,
    M_CONV = 4'h2,
    M_WAIT = 4'h4,
    M_STORE = 4'h8
  } mstate_t;

  logic             busy_q;
  logic             cyclic_q;
  logic             raw_q;
  target_t          tgt_q;
  logic [4:0]       avg_n_q;
  logic [2:0]       avg_log_q;
  logic [4:0]       avg_cnt_q;
  logic [27:0]      acc_s_q;
  logic [27:0]      acc_t_q;
  logic             sat_q;
  sample_t          res_q;
  mstate_t          ms_q;
  logic [2:0]       rd_idx_q;
  logic             rd_act_q;
  logic [7:0]       stat_q;
  logic [7:0]       byte_d;
  logic             buf_ready;
  logic             accept;
  logic [2:0]       rd_len;

  function automatic logic [23:0] correct(input logic [23:0] raw,
                                          input logic [23:0] gain,
                                          input logic [23:0] off);
    logic [47:0] p;
    p = raw * gain;
    correct = p[39:16] + off;
  endfunction

  function automatic logic [7:0] pick(input logic [23:0] v,
                                      input logic [1:0] i);
    pick = (i == 2'h0) ? v[23:16] : (i == 2'h1) ? v[15:8] : v[7:0];
  endfunction

  // New commands refused while busy, stop still honoured in cyclic
  assign accept = cmd_valid_i &&
                  (!busy_q || (cyclic_q && cmd_data_i == `CMD_STOP_CYCLIC));
  assign cmd_reject_o = cmd_valid_i && !accept;
  assign busy_o   = busy_q;
  assign cyclic_o = cyclic_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cyclic_q  <= 1'b0;
      raw_q     <= 1'b1;
      tgt_q     <= TGT_BOTH;
      avg_n_q   <= 5'h01;
      avg_log_q <= 3'h0;
    end
    else if (accept)
    begin
      if (cmd_data_i == `CMD_START_CYCLIC)
      begin
        cyclic_q <= 1'b1;
        tgt_q    <= TGT_BOTH;
        raw_q    <= 1'b0;
        avg_n_q  <= 5'h01;
        avg_log_q <= 3'h0;
      end
      else if (cmd_data_i == `CMD_STOP_CYCLIC)
      begin
        cyclic_q <= 1'b0;
      end
      else if (cmd_data_i == `CMD_RAW_BOTH)
      begin
        raw_q <= 1'b1;
        tgt_q <= TGT_BOTH;
        avg_n_q <= 5'h01;
        avg_log_q <= 3'h0;
      end
      else if (cmd_data_i == `CMD_RAW_SENSOR)
      begin
        raw_q <= 1'b1;
        tgt_q <= TGT_SENSOR;
        avg_n_q <= 5'h01;
        avg_log_q <= 3'h0;
      end
      else if (cmd_data_i == `CMD_RAW_TEMP)
      begin
        raw_q <= 1'b1;
        tgt_q <= TGT_TEMP;
        avg_n_q <= 5'h01;
        avg_log_q <= 3'h0;
      end
      else if ((cmd_data_i & `CMD_CORR_MASK) == `CMD_CORR_BASE &&
               cmd_data_i[2:0] <= 3'h4)
      begin
        raw_q <= 1'b0;
        tgt_q <= TGT_BOTH;
        avg_log_q <= cmd_data_i[2:0];
        avg_n_q <= 5'h01 << cmd_data_i[2:0];
      end
    end
  end

  // Busy follows the measurement; held high through cyclic mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_q <= 1'b0;
    end
    else if (accept && cmd_data_i == `CMD_STOP_CYCLIC)
    begin
      busy_q <= 1'b0;
    end
    else if (accept && cmd_data_i != `CMD_STOP_CYCLIC)
    begin
      busy_q <= 1'b1;
    end
    else if (ms_q == M_STORE && !cyclic_q)
    begin
      busy_q <= 1'b0;
    end
  end

  // Conversion and averaging sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ms_q <= M_IDLE;
      avg_cnt_q <= 5'h00;
      acc_s_q <= '0;
      acc_t_q <= '0;
      res_q <= '0;
      sat_q <= 1'b0;
    end
    else if (accept && cmd_data_i == `CMD_STOP_CYCLIC)
    begin
      // Stop drops the cyclic measurement in flight
      ms_q <= M_IDLE;
    end
    else
    begin
      case (ms_q)
        M_IDLE:
        begin
          if (busy_q)
          begin
            ms_q <= M_CONV;
            avg_cnt_q <= 5'h00;
            acc_s_q <= '0;
            acc_t_q <= '0;
          end
        end
        M_CONV:
        begin
          ms_q <= M_WAIT;
        end
        M_WAIT:
        begin
          if (conv_done_i)
          begin
            if (raw_q)
            begin
              acc_s_q <= {4'h0, conv_data_i.sensor};
              acc_t_q <= {4'h0, conv_data_i.temp};
            end
            else
            begin
              acc_s_q <= acc_s_q + {4'h0, correct(conv_data_i.sensor,
                         coef_gain_i, coef_offset_i)};
              acc_t_q <= acc_t_q + {4'h0, conv_data_i.temp};
            end
            avg_cnt_q <= avg_cnt_q + 5'h01;
            ms_q <= (avg_cnt_q + 5'h01 >= avg_n_q) ? M_STORE : M_CONV;
          end
        end
        M_STORE:
        begin
          res_q.sensor <= 24'(acc_s_q >> avg_log_q);
          res_q.temp   <= 24'(acc_t_q >> avg_log_q);
          sat_q <= |(acc_s_q[27:24] & (4'hf << avg_log_q));
          ms_q <= M_IDLE;
        end
        default:
        begin
          ms_q <= M_IDLE;
        end
      endcase
    end
  end

  assign conv_start_o = (ms_q == M_CONV);

  // Readout: status byte, then one or two 24-bit results
  assign rd_len = (tgt_q == TGT_BOTH) ? 3'h7 : 3'h4;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_act_q <= 1'b0;
      rd_idx_q <= 3'h0;
      stat_q   <= 8'h00;
    end
    else if (!rd_act_q && read_req_i)
    begin
      rd_act_q <= 1'b1;
      rd_idx_q <= 3'h0;
      stat_q <= {1'b0, 1'b1, busy_q, !cyclic_q && !sleep_i, cyclic_q,
                 sleep_i, 1'b0, sat_q};
    end
    else if (rd_act_q && buf_ready)
    begin
      rd_idx_q <= rd_idx_q + 3'h1;
      if (rd_idx_q + 3'h1 == rd_len)
      begin
        rd_act_q <= 1'b0;
      end
    end
  end

  always_comb
  begin
    byte_d = stat_q;
    if (rd_idx_q != 3'h0)
    begin
      if (tgt_q == TGT_TEMP)
      begin
        byte_d = pick(res_q.temp, 2'(rd_idx_q - 3'h1));
      end
      else if (rd_idx_q <= 3'h3)
      begin
        byte_d = pick(res_q.sensor, 2'(rd_idx_q - 3'h1));
      end
      else
      begin
        byte_d = pick(res_q.temp, 2'(rd_idx_q - 3'h4));
      end
    end
  end

  out_buffer #(.WIDTH(8)) u_buf
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (rd_act_q),
    .in_ready_o  (buf_ready),
    .in_data_i   (byte_d),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (rd_data_o.data)
  );
endmodule

// >>> hdl/out_buffer.sv
// Two-entry byte buffer between the readout sequencer and the link.
// Assumes one clock; full and empty are exact.
module out_buffer
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Filling side
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_q [2];
  logic             wp_q;
  logic             rp_q;
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wp_q <= ~wp_q;
      end
      if (pop)
      begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Output word registered from the head slot; a word pushed while the
  // only stored word drains becomes the new head directly
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_data_o <= '0;
    end
    else if (push && (!out_valid_o || (pop && cnt_q == 2'h1)))
    begin
      out_data_o <= in_data_i;
    end
    else if (pop)
    begin
      out_data_o <= mem_q[~rp_q];
    end
  end
endmodule

// >>> test/conv_model.sv
// Behavioural converter answering each start pulse after a set delay.
// Assumes start pulses arrive one at a time.
module conv_model
  import meas_cmd_pkg::*;
(
  // Clock and request
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [7:0] delay_i,
  input  wire sample_t    samp_i,
  // Answer
  output      logic       done_o,
  output      sample_t    data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    done_o = 0;
    data_o = '1;
    forever
    begin
      @(negedge clk_i);
      if (start_i)
      begin
        repeat (delay_i) @(posedge clk_i);
        #2 done_o = 1;
        data_o = samp_i;
        @(posedge clk_i);
        // Data is only valid with done, so it flips afterwards
        #2 done_o = 0;
        data_o = ~samp_i;
      end
    end
  end
endmodule

// >>> test/meas_cmd_checker.sv
// Port assertions of the measurement command and readout logic.
// Assumes it is bound to every meas_cmd_readout instance.
module meas_cmd_checker
(
  // Watched ports
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                cmd_valid_i,
  input wire logic [7:0]          cmd_data_i,
  input wire logic                cmd_reject_o,
  input wire logic                rd_valid_o,
  input wire logic                rd_ready_i,
  input wire meas_cmd_pkg::byte_t rd_data_o,
  input wire logic                conv_start_o,
  input wire logic                conv_done_i,
  input wire logic                busy_o,
  input wire logic                cyclic_o
);
  import meas_cmd_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cmd_valid_i && !busy_o;
  endsequence
  sequence s_stop;
    cmd_valid_i && cyclic_o && cmd_data_i == 8'hbf;
  endsequence
  chk_reject_busy: assert property (
    cmd_valid_i && busy_o && !(cyclic_o && cmd_data_i == 8'hbf)
    |-> cmd_reject_o) else $error("command not refused while busy");
  chk_take_clean: assert property (
    s_take |-> !cmd_reject_o ##1 busy_o)
    else $error("accepted command did not set busy");
  chk_raw_start: assert property (
    s_take ##0 (cmd_data_i inside {8'ha0, 8'ha1, 8'ha2})
    |-> ##2 conv_start_o) else $error("raw command started no conversion");
  chk_enter_cyclic: assert property (
    s_take ##0 (cmd_data_i == 8'hab) |-> ##[1:2] cyclic_o)
    else $error("cyclic mode not entered");
  chk_cyclic_busy: assert property (
    cyclic_o |-> busy_o) else $error("busy low in cyclic mode");
  chk_stop_cyclic: assert property (
    s_stop |-> !cmd_reject_o ##[1:1000] !cyclic_o)
    else $error("cyclic mode not left after stop");
  chk_busy_clear: assert property (
    conv_done_i && busy_o && !cyclic_o |-> ##[1:1000] !busy_o)
    else $error("busy not cleared after result");
  chk_byte_hold: assert property (
    rd_valid_o && !rd_ready_i |=> rd_valid_o && $stable(rd_data_o))
    else $error("read byte lost during stall");
endmodule
bind meas_cmd_readout meas_cmd_checker chk (.*);

// >>> test/sensor_measurement_command_readout_tb.sv
// Self-checking bench of the measurement command and readout logic.
// Assumes the converter model and the bound checker.
module sensor_measurement_command_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import meas_cmd_pkg::*;
  logic        clk_i = 0, rst_i = 1, cmd_valid_i = 0, read_req_i = 0;
  logic        rd_ready_i = 0, sleep_i = 0, conv_done_i, cmd_reject_o;
  logic        rd_valid_o, conv_start_o, busy_o, cyclic_o;
  logic [7:0]  cmd_data_i = 0, delay = 1;
  logic [23:0] coef_gain_i = 24'h010000, coef_offset_i = 0;
  logic [15:0] e;
  logic [15:0] expq[$];
  byte_t       rd_data_o;
  sample_t     conv_data_i, samp = 0;
  int          seed = 78, error_cnt = 0, comparisons = 0;

  meas_cmd_readout dut (.*);
  conv_model conv
  (
    .clk_i   (clk_i),
    .start_i (conv_start_o),
    .delay_i (delay),
    .samp_i  (samp),
    .done_o  (conv_done_i),
    .data_o  (conv_data_i)
  );

  initial
    forever #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
    #2 rd_ready_i = 1'($random(seed));

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic quit();
    error_cnt++;
    print_verdict();
  endtask
  task automatic check(string nm, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic send(logic [7:0] c, logic rej);
    cmd_data_i = c;
    cmd_valid_i = 1;
    #1 check("reject", {7'h0, rej}, {7'h0, cmd_reject_o});
    tick();
    cmd_valid_i = 0;
    tick();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 2000)
    begin
      tick();
      n++;
    end
    if (n == 2000)
      quit();
  endtask
  // Notes status and results, then fetches them with one read
  task automatic rd(logic [7:0] st, logic [23:0] a, b, int nb);
    int n;
    expq.push_back({8'h68, st});
    for (int i = 0; i < nb; i++)
      for (int j = 2; j >= 0; j--)
        expq.push_back({8'hff, 8'((i ? b : a) >> (8 * j))});
    read_req_i = 1;
    tick();
    read_req_i = 0;
    n = 0;
    while (expq.size() > 0 && n < 500)
    begin
      tick();
      n++;
    end
    if (n == 500)
      quit();
    tick(2);
  endtask
  function automatic logic [23:0] corr(logic [23:0] x);
    logic [47:0] p;
    p = x * coef_gain_i;
    return p[39:16] + coef_offset_i;
  endfunction

  // Bytes without a note are compared against an impossible value
  always @(posedge clk_i)
    if (!rst_i && rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
    begin
      e = expq.size() ? expq.pop_front() : 16'h00aa;
      check("rd_data", e[7:0], rd_data_o.data & e[15:8]);
    end

  initial
  begin
    tick(8);
    rst_i = 0;
    check("busy", 8'h0, {7'h0, busy_o});
    rd(8'h40, 24'h0, 24'h0, 2);
    for (int t = 0; t < 3; t++)
    begin
      samp = 48'({$random(seed), $random(seed)}) & 48'h0fffff0fffff;
      delay = 8'(t * 4 + 1);
      send(8'ha0 + 8'(t), 0);
      wait_idle();
      rd(8'h40, t == 2 ? samp.temp : samp.sensor, samp.temp,
         t == 0 ? 2 : 1);
    end
    delay = 20;
    send(8'ha0, 0);
    send(8'ha1, 1);
    wait_idle();
    rd(8'h40, samp.sensor, samp.temp, 2);
    delay = 2;
    for (int k = 0; k < 5; k++)
    begin
      coef_gain_i = 24'h010000 | 24'($random(seed) & 32'hffff);
      coef_offset_i = 24'($random(seed) & 32'hffff);
      send(8'hb0 + 8'(k), 0);
      wait_idle();
      rd(8'h40, corr(samp.sensor), samp.temp, 2);
    end
    sleep_i = 1;
    send(8'hab, 0);
    sleep_i = 0;
    tick(60);
    check("cyclic", 8'h1, {7'h0, cyclic_o});
    rd(8'h68, corr(samp.sensor), samp.temp, 2);
    send(8'ha0, 1);
    send(8'hbf, 0);
    wait_idle();
    check("cyclic", 8'h0, {7'h0, cyclic_o});
    rd(8'h40, corr(samp.sensor), samp.temp, 2);
    print_verdict();
  end
endmodule
